/* src/llt_timers.sv */
// Four latency counters for a 10G loopback test on the MAC clock.
// Assumes all watched buses are synchronous to clk; no crossing needed.
`timescale 1ns/100ps
module llt_timers
   import llt_pkg::*;
#(
   parameter int CNT_W = LLT_CNT_W,
   parameter int WCNT_W = LLT_WCNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Loop control
   input wire logic loop_start,
   input wire logic [WCNT_W-1:0] total_transfer_size,
   // Tx streaming bus
   input wire logic tx_stream_first_beat,
   input wire logic tx_stream_valid,
   input wire logic tx_stream_ready,
   // Tx XGMII
   input wire logic [63:0] xgmii_transmit_word,
   input wire logic [7:0] xgmii_transmit_ctl,
   // Rx XGMII
   input wire logic [63:0] xgmii_receive_word,
   input wire logic [7:0] xgmii_receive_ctl,
   // Rx streaming bus
   input wire logic rx_stream_first_beat,
   input wire logic rx_stream_valid,
   // User FIFO strobes
   input wire logic tx_fifo_write_strobe,
   input wire logic rx_fifo_read_strobe,
   // Counter values
   output logic [CNT_W-1:0] tx_mac_latency_counter,
   output logic [CNT_W-1:0] phys_path_latency_counter,
   output logic [CNT_W-1:0] rx_mac_latency_counter,
   output logic [CNT_W-1:0] total_transfer_counter,
   output logic [WCNT_W-1:0] rx_word_count,
   // Flags
   output logic phys_count_begin_flag,
   output logic phys_count_end_flag,
   output logic rx_count_begin_flag,
   output logic rx_count_end_flag,
   output logic total_count_begin_flag,
   output logic total_count_end_flag,
   output logic tx_count_begin_flag,
   output logic tx_count_end_flag
);
   // Tx first data detection
   logic tx_pre_seen_reg;
   logic tx_pre_seen_next;
   logic tx_pre_match;
   logic tx_first_data;
   logic tx_beat;
   // Rx first data detection
   llt_rx_state_type rx_state_reg;
   llt_rx_state_type rx_state_next;
   logic rx_pre64_match;
   logic rx_pre32_match;
   logic rx_first_data;
   // Received word counter
   logic [WCNT_W-1:0] wcnt_reg;
   logic [WCNT_W-1:0] wcnt_next;
   logic total_done;
   // Counter raw values and flags
   logic [CNT_W-1:0] cnt_val [4];
   logic [3:0] beg_f;
   logic [3:0] end_f;
   logic [3:0] start_ev;
   logic [3:0] stop_ev;
   // Output registers
   logic [CNT_W-1:0] cnt_out_reg [4];
   logic [3:0] beg_out_reg;
   logic [3:0] end_out_reg;
   logic [WCNT_W-1:0] wcnt_out_reg;

   // Preamble compare, used on both XGMII directions
   function automatic logic pre64(input logic [63:0] d, input logic [7:0] c);
      pre64 = (d == LLT_PRE_SFD64) && (c == LLT_CTL_START64);
   endfunction

   // Transmit side: the payload follows the preamble word by one clock
   assign tx_beat = tx_stream_first_beat & tx_stream_valid &
      tx_stream_ready;
   assign tx_pre_match = pre64(xgmii_transmit_word, xgmii_transmit_ctl);
   assign tx_pre_seen_next = tx_pre_match;
   assign tx_first_data = tx_pre_seen_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_pre_seen_reg <= 1'b0;
      end else begin
         tx_pre_seen_reg <= tx_pre_seen_next;
      end
   end

   // Receive side: aligned start word, or delimiter in upper half with
   // 32 payload bits in the same word
   assign rx_pre64_match = pre64(xgmii_receive_word, xgmii_receive_ctl);
   assign rx_pre32_match = (xgmii_receive_word[63:32] == LLT_PRE_SFD32) &&
      (xgmii_receive_ctl == LLT_CTL_START32);

   // Detector fires once per loop so a later frame cannot re-trigger
   always_comb begin
      rx_state_next = rx_state_reg;
      rx_first_data = 1'b0;
      unique case (rx_state_reg)
         LLT_RX_IDLE: begin
            if (rx_pre64_match) begin
               rx_state_next = LLT_RX_WAIT;
            end
         end
         LLT_RX_WAIT: begin
            // Payload word after the aligned preamble
            rx_first_data = 1'b1;
            rx_state_next = LLT_RX_DONE;
         end
         LLT_RX_DONE: begin
            rx_state_next = LLT_RX_DONE;
         end
         default: begin
            rx_state_next = LLT_RX_IDLE;
         end
      endcase
      if (rx_state_reg == LLT_RX_IDLE && !rx_pre64_match &&
         rx_pre32_match) begin
         rx_first_data = 1'b1;
         rx_state_next = LLT_RX_DONE;
      end
      if (loop_start) begin
         rx_state_next = LLT_RX_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_state_reg <= LLT_RX_IDLE;
      end else begin
         rx_state_reg <= rx_state_next;
      end
   end

   // Received word counter; loop start restarts it
   assign wcnt_next = loop_start ? LLT_WCNT_RST[WCNT_W-1:0] :
      (rx_fifo_read_strobe ? wcnt_reg + 1'b1 : wcnt_reg);
   // Compare with the stored count so the end marks the last word read
   assign total_done = (wcnt_reg == total_transfer_size) &&
      (wcnt_reg != '0);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wcnt_reg <= LLT_WCNT_RST[WCNT_W-1:0];
      end else begin
         wcnt_reg <= wcnt_next;
      end
   end

   // Event routing: index 0 tx MAC, 1 physical, 2 rx MAC, 3 total
   assign start_ev[0] = tx_beat;
   assign stop_ev[0] = tx_first_data;
   assign start_ev[1] = tx_first_data;
   assign stop_ev[1] = rx_first_data;
   assign start_ev[2] = rx_first_data;
   assign stop_ev[2] = rx_stream_first_beat & rx_stream_valid;
   assign start_ev[3] = tx_fifo_write_strobe;
   assign stop_ev[3] = total_done;

   // Four identical counters
   generate
      for (genvar i = 0; i < 4; i++) begin : g_cnt
         llt_counter #(
            .CNT_W(CNT_W)
         ) u_cnt (
            .clk(clk),
            .sys_rst(sys_rst),
            .loop_clear(loop_start),
            .start_event(start_ev[i]),
            .stop_event(stop_ev[i]),
            .begin_flag(beg_f[i]),
            .end_flag(end_f[i]),
            .count(cnt_val[i])
         );
      end
   endgenerate

   // Output registers; one clock behind the counters, read once the loop
   // has settled so the lag does not matter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            cnt_out_reg[i] <= LLT_CNT_RST[CNT_W-1:0];
         end
         beg_out_reg <= 4'h0;
         end_out_reg <= 4'h0;
         wcnt_out_reg <= LLT_WCNT_RST[WCNT_W-1:0];
      end else begin
         for (int i = 0; i < 4; i++) begin
            cnt_out_reg[i] <= cnt_val[i];
         end
         beg_out_reg <= beg_f;
         end_out_reg <= end_f;
         wcnt_out_reg <= wcnt_reg;
      end
   end

   assign tx_mac_latency_counter = cnt_out_reg[0];
   assign phys_path_latency_counter = cnt_out_reg[1];
   assign rx_mac_latency_counter = cnt_out_reg[2];
   assign total_transfer_counter = cnt_out_reg[3];
   assign rx_word_count = wcnt_out_reg;
   assign tx_count_begin_flag = beg_out_reg[0];
   assign tx_count_end_flag = end_out_reg[0];
   assign phys_count_begin_flag = beg_out_reg[1];
   assign phys_count_end_flag = end_out_reg[1];
   assign rx_count_begin_flag = beg_out_reg[2];
   assign rx_count_end_flag = end_out_reg[2];
   assign total_count_begin_flag = beg_out_reg[3];
   assign total_count_end_flag = end_out_reg[3];
endmodule

/* src/llt_pkg.sv */
// Constants shared by the loopback latency timers.
// Assumes a 64-bit XGMII data word with byte 0 in bits 7:0.
package llt_pkg;
   // Counter width seen by software
   localparam int LLT_CNT_W = 32;
   localparam logic [31:0] LLT_CNT_RST = 32'h0000_0000;
   // Received word counter width and reset value
   localparam int LLT_WCNT_W = 32;
   localparam logic [31:0] LLT_WCNT_RST = 32'h0000_0000;
   // Start character 0xFB, preamble (6 bytes 0x55) plus start-of-frame delimiter 0xD5
   localparam logic [63:0] LLT_PRE_SFD64 = 64'hD555_5555_5555_55FB;
   // High half when a 32-bit payload follows: start character, 2 preamble bytes then delimiter
   localparam logic [31:0] LLT_PRE_SFD32 = 32'hD555_55FB;
   // Control lane masks for the two start formats
   localparam logic [7:0] LLT_CTL_START64 = 8'h01;
   localparam logic [7:0] LLT_CTL_START32 = 8'h1F;
   localparam logic [7:0] LLT_CTL_DATA = 8'h00;
   // Rx first-data detector states
   typedef enum logic [2:0] {
      LLT_RX_IDLE = 3'h1,
      LLT_RX_WAIT = 3'h2,
      LLT_RX_DONE = 3'h4
   } llt_rx_state_type;
endpackage

/* src/llt_counter.sv */
// One latency counter with its sticky start and end flags.
// Assumes start and stop pulses come from logic on the same clock.
`timescale 1ns/100ps
module llt_counter
   import llt_pkg::*;
#(
   parameter int CNT_W = LLT_CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic loop_clear,
   input wire logic start_event,
   input wire logic stop_event,
   // State
   output logic begin_flag,
   output logic end_flag,
   output logic [CNT_W-1:0] count
);
   logic begin_reg;
   logic begin_next;
   logic end_reg;
   logic end_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic run;

   // Flags stick until the loop clear; clear wins over a start in the same cycle
   assign begin_next = loop_clear ? 1'b0 : (begin_reg | start_event);
   assign end_next = loop_clear ? 1'b0 : (end_reg | stop_event);
   assign run = begin_reg & ~end_reg;
   assign count_next = loop_clear ? LLT_CNT_RST[CNT_W-1:0] :
      (run ? count_reg + 1'b1 : count_reg);

   // State registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         begin_reg <= 1'b0;
         end_reg <= 1'b0;
         count_reg <= LLT_CNT_RST[CNT_W-1:0];
      end else begin
         begin_reg <= begin_next;
         end_reg <= end_next;
         count_reg <= count_next;
      end
   end

   assign begin_flag = begin_reg;
   assign end_flag = end_reg;
   assign count = count_reg;
endmodule

/* tb/llt_props.sv */
// Checker for three of the four latency timers (tx, physical, rx), bound to llt_timers.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module llt_props
   import llt_pkg::*;
(
   // Clock, reset and loop control
   input wire logic clk, sys_rst, loop_start,
   // Watched buses
   input wire logic tx_stream_first_beat, tx_stream_valid, tx_stream_ready,
   input wire logic [63:0] xgmii_transmit_word,
   input wire logic [7:0] xgmii_transmit_ctl,
   input wire logic rx_stream_first_beat, rx_stream_valid,
   // Flags and counts
   input wire logic tx_count_begin_flag, tx_count_end_flag,
   input wire logic phys_count_begin_flag, phys_count_end_flag,
   input wire logic rx_count_begin_flag, rx_count_end_flag,
   input wire logic [31:0] rx_mac_latency_counter, tx_mac_latency_counter
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Flag outputs lag their cause by two samples; the tx end flag lags the preamble word by three
   a_tx_begin_cause: assert property (
      $rose(tx_count_begin_flag) |-> $past(tx_stream_first_beat &&
      tx_stream_valid && tx_stream_ready, 2)) else $error("tx begin cause");
   a_tx_end_cause: assert property (
      $rose(tx_count_end_flag) |-> $past(xgmii_transmit_word, 3) ==
      LLT_PRE_SFD64 && $past(xgmii_transmit_ctl, 3) == LLT_CTL_START64)
      else $error("tx end cause");
   a_phys_begin_link: assert property (
      $rose(tx_count_end_flag) |-> $rose(phys_count_begin_flag))
      else $error("phys begin link");
   a_rx_begin_link: assert property (
      $rose(phys_count_end_flag) |-> $rose(rx_count_begin_flag))
      else $error("rx begin link");
   a_rx_end_cause: assert property (
      $rose(rx_count_end_flag) |->
      $past(rx_stream_first_beat && rx_stream_valid, 2))
      else $error("rx end cause");
   // A count moves by one while armed, or drops to zero on a clear
   a_rx_step_one: assert property (
      $changed(rx_mac_latency_counter) |-> rx_mac_latency_counter == 0 ||
      (rx_count_begin_flag && rx_mac_latency_counter ==
      $past(rx_mac_latency_counter) + 1)) else $error("rx step");
   a_tx_hold_value: assert property (
      $changed(tx_mac_latency_counter) && $past(tx_count_end_flag) |->
      !tx_count_end_flag) else $error("tx count moved after end");
   a_flag_stays_set: assert property (
      $fell(tx_count_end_flag) || $fell(rx_count_begin_flag) |->
      $past(loop_start, 2)) else $error("flag fell without clear");
   cover property ($rose(phys_count_end_flag));
   cover property ($rose(rx_count_end_flag));
   cover property ($fell(tx_count_end_flag));
endmodule
bind llt_timers llt_props P (.clk, .sys_rst, .loop_start,
   .tx_stream_first_beat, .tx_stream_valid, .tx_stream_ready,
   .xgmii_transmit_word, .xgmii_transmit_ctl, .rx_stream_first_beat,
   .rx_stream_valid, .tx_count_begin_flag, .tx_count_end_flag,
   .phys_count_begin_flag, .phys_count_end_flag, .rx_count_begin_flag,
   .rx_count_end_flag, .rx_mac_latency_counter, .tx_mac_latency_counter);

/* tb/llt_far_side.sv */
// Model of the MAC, offload engine and pattern logic around the timers.
// Assumes the bench calls run once per loop; drives on falling edges.
`timescale 1ns/100ps
module llt_far_side
   import llt_pkg::*;
(
   input wire logic clk,
   output logic tx_fifo_write_strobe, rx_fifo_read_strobe,
   output logic tx_stream_first_beat, tx_stream_valid, tx_stream_ready,
   output logic rx_stream_first_beat, rx_stream_valid,
   output logic [63:0] xgmii_transmit_word, xgmii_receive_word,
   output logic [7:0] xgmii_transmit_ctl, xgmii_receive_ctl
);
   localparam logic [71:0] IDLE = {64'h0707_0707_0707_0707, 8'hFF};
   localparam logic [71:0] DATA = {64'h0123_4567_89AB_CDEF, LLT_CTL_DATA};
   initial begin
      {tx_fifo_write_strobe, rx_fifo_read_strobe} = 2'h0;
      {tx_stream_first_beat, tx_stream_valid, tx_stream_ready} = 3'h0;
      {rx_stream_first_beat, rx_stream_valid} = 2'h0;
      {xgmii_transmit_word, xgmii_transmit_ctl} = IDLE;
      {xgmii_receive_word, xgmii_receive_ctl} = IDLE;
   end
   // One loop of traffic; late beats at step 22 belong to no new frame
   task automatic run(input bit half);
      for (int c = 1; c <= 24; c++) begin
         @(negedge clk);
         tx_fifo_write_strobe <= (c == 1);
         // Beat 1 is no frame start; beat 2 stalls for ready
         tx_stream_valid <= (c <= 3 || c == 22);
         tx_stream_ready <= (c == 1 || c == 3 || c == 22);
         tx_stream_first_beat <= (c == 2 || c == 3 || c == 22);
         {xgmii_transmit_word, xgmii_transmit_ctl} <= (c == 5) ?
            {LLT_PRE_SFD64, LLT_CTL_START64} : (c == 6) ? DATA : IDLE;
         // Half form packs delimiter and payload into one word
         {xgmii_receive_word, xgmii_receive_ctl} <= (c != 10) ?
            ((c == 11 && !half) ? DATA : IDLE) : half ?
            {LLT_PRE_SFD32, 32'hA1B2_C3D4, LLT_CTL_START32} :
            {LLT_PRE_SFD64, LLT_CTL_START64};
         // Step 14 shows a first beat that is not yet valid
         rx_stream_first_beat <= (c == 14 || c == 15 || c == 22);
         rx_stream_valid <= (c == 15 || c == 22);
         rx_fifo_read_strobe <= (c >= 17 && c <= 20);
      end
   endtask
endmodule

/* tb/llt_timers_tb.sv */
// Self-checking bench for llt_timers: two loops, aligned and half form.
// Assumes the far-side model supplies every watched bus.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module llt_timers_tb;
   import llt_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, loop_start = 1'b0;
   logic [31:0] total_transfer_size = 32'h4;
   logic tx_fifo_write_strobe, rx_fifo_read_strobe, tx_stream_first_beat;
   logic tx_stream_valid, tx_stream_ready, rx_stream_first_beat;
   logic rx_stream_valid;
   logic [63:0] xgmii_transmit_word, xgmii_receive_word;
   logic [7:0] xgmii_transmit_ctl, xgmii_receive_ctl;
   logic [31:0] tx_mac_latency_counter, phys_path_latency_counter;
   logic [31:0] rx_mac_latency_counter, total_transfer_counter;
   logic [31:0] rx_word_count;
   logic [7:0] flags;
   logic [127:0] held;
   int err_total = 0, num_checks = 0;
   llt_far_side FAR (.clk, .tx_fifo_write_strobe, .rx_fifo_read_strobe,
      .tx_stream_first_beat, .tx_stream_valid, .tx_stream_ready,
      .rx_stream_first_beat, .rx_stream_valid,
      .xgmii_transmit_word, .xgmii_receive_word, .xgmii_transmit_ctl,
      .xgmii_receive_ctl);
   llt_timers DUT (.clk, .sys_rst, .loop_start, .total_transfer_size,
      .tx_stream_first_beat, .tx_stream_valid,
      .tx_stream_ready, .xgmii_transmit_word,
      .xgmii_transmit_ctl, .xgmii_receive_word, .xgmii_receive_ctl,
      .rx_stream_first_beat, .rx_stream_valid,
      .tx_fifo_write_strobe, .rx_fifo_read_strobe, .tx_mac_latency_counter,
      .phys_path_latency_counter, .rx_mac_latency_counter,
      .total_transfer_counter, .rx_word_count,
      .phys_count_begin_flag(flags[0]), .phys_count_end_flag(flags[1]),
      .rx_count_begin_flag(flags[2]), .rx_count_end_flag(flags[3]),
      .total_count_begin_flag(flags[4]), .total_count_end_flag(flags[5]),
      .tx_count_begin_flag(flags[6]), .tx_count_end_flag(flags[7]));
   initial forever #5 clk = ~clk;
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Clear, run one loop, then read all counts once the loop is over
   task run_loop(input bit half, input logic [31:0] phys, rx);
      @(negedge clk) loop_start <= 1'b1;
      @(negedge clk) loop_start <= 1'b0;
      @(negedge clk);
      `CHK({tx_mac_latency_counter, rx_word_count, flags}, 72'h0)
      FAR.run(half);
      `CHK(tx_mac_latency_counter, 32'h3)
      `CHK(phys_path_latency_counter, phys)
      `CHK(rx_mac_latency_counter, rx)
      `CHK(total_transfer_counter, 32'h14)
      `CHK(rx_word_count, 32'h4)
      `CHK(flags, 8'hFF)
      held = {tx_mac_latency_counter, phys_path_latency_counter,
         rx_mac_latency_counter, total_transfer_counter};
      repeat (5) @(negedge clk);
      `CHK({tx_mac_latency_counter, phys_path_latency_counter,
         rx_mac_latency_counter, total_transfer_counter}, held)
   endtask
   initial begin
      repeat (6) @(negedge clk);
      sys_rst <= 1'b0;
      run_loop(1'b0, 32'h5, 32'h4);
      run_loop(1'b1, 32'h4, 32'h5);
      print_verdict;
   end
   // Both loops need well under a thousand cycles
   initial begin
      #20000;
      err_total++;
      print_verdict;
   end
endmodule
